//--- hw/cdbp_pkg.sv
// Shared constants and types for the processor data bus parity path.
package cdbp_pkg;

    // Geometry of the split data bus
    localparam int CDBP_LANES = 8;
    localparam int CDBP_LANE_W = 8;
    localparam int CDBP_HALF_W = 32;
    localparam int CDBP_BUS_W = 64;

    // Beats per transaction kind
    localparam int CDBP_BURST_BEATS = 4;
    localparam int CDBP_SINGLE_BEATS = 1;

    // Lanes 0-3 live in the high half; parity bit n always covers lane n
    localparam logic [7:0] CDBP_HIGH_LANES = 8'h0F;
    localparam logic [7:0] CDBP_ALL_LANES = 8'hFF;

    // Parity error pipeline: flag shows two cycles after the acknowledge
    localparam int CDBP_PERR_DELAY = 2;

    // Reset values
    localparam logic [63:0] CDBP_DATA_RST = 64'h0000_0000_0000_0000;
    localparam logic [7:0] CDBP_LANES_RST = 8'h00;

    // Data tenure sequencing
    typedef enum logic [1:0] {
        CDBP_IDLE,
        CDBP_WAIT_GNT,
        CDBP_XFER,
        CDBP_RD_TAIL
    } cdbp_state_e;

endpackage

//--- hw/cdbp_lane_par.sv
// One byte lane: odd parity generation and even parity detection.
`timescale 1ns/1ps
module cdbp_lane_par
    import cdbp_pkg::*;
(
    input wire logic [7:0] lane_byte, // Byte on this lane
    input wire logic par_in,          // Parity bit received with it
    output logic par_gen,             // Odd parity bit for lane_byte
    output logic even_err             // Byte plus bit hold an even count of ones
);
    // Nine bits must hold an odd count of ones
    assign par_gen = ~(^lane_byte);
    assign even_err = ~(^{lane_byte, par_in});
endmodule

//--- hw/cdbp_beat_buf.sv
// Small store for the beats of one read tenure, registered read port.
`timescale 1ns/1ps
module cdbp_beat_buf
    import cdbp_pkg::*;
#(
    parameter int WIDTH = CDBP_BUS_W,   // Bits per beat
    parameter int DEPTH = CDBP_BURST_BEATS, // Beats held
    parameter int AW = $clog2(DEPTH)    // Index width
) (
    input wire logic clk,                // Bus clock
    input wire logic wr_en,              // Store one beat
    input wire logic [AW-1:0] wr_addr,   // Beat index written
    input wire logic [WIDTH-1:0] wr_data, // Beat written
    input wire logic [AW-1:0] rd_addr,   // Beat index read
    output logic [WIDTH-1:0] rd_data_q   // Beat read, one cycle later
);
    logic [WIDTH-1:0] mem [DEPTH];

    generate
        if (DEPTH < 2) begin : g_depth_chk
            $error("cdbp_beat_buf needs at least two entries");
        end
    endgenerate

    // No reset on the array; contents are only read after a tenure fills it
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read keeps the output free of array decode glitches
    always_ff @(posedge clk) begin
        rd_data_q <= mem[rd_addr];
    end
endmodule

//--- hw/cdbp_data_path.sv
// Data tenure engine: drives write beats, samples read beats, checks parity.
`timescale 1ns/1ps

module cdbp_data_path
    import cdbp_pkg::*;
#(
    parameter int BURST_BEATS = CDBP_BURST_BEATS, // Beats in a cache burst
    parameter int BW = $clog2(BURST_BEATS)        // Beat index width
) (
    input wire logic clk,                       // Bus clock, 125 MHz
    input wire logic nrst,                      // Async reset, active low
    // Core request side
    input wire logic req_valid,                 // Transaction offered
    output logic req_ready,                     // Engine idle, takes offer
    input wire logic req_write,                 // 1 write, 0 read
    input wire logic req_burst,                 // Cache burst of four beats
    input wire logic req_dstore,                // Direct-store transfer
    input wire logic [7:0] req_lanes,           // Selected byte lanes, bit n = lane n
    output logic wr_pull,                       // Present next write beat now
    input wire logic [63:0] wr_data,            // Write beat, lane 0 in [63:56]
    output logic rd_done,                       // Read tenure complete, pulse
    input wire logic [BW-1:0] rd_idx,           // Read beat index to fetch
    output logic [63:0] rd_word,                // Fetched read beat, registered
    // Configuration and status
    input wire logic parity_check_en,           // Data parity checking on
    input wire logic machine_check_enable,      // Machine check rather than checkstop
    output logic machine_check_req,             // Machine check request, pulse
    output logic checkstop,                     // Checkstop entered, sticky
    // Bus pins
    input wire logic data_bus_grant_n,          // Data bus grant
    input wire logic transfer_acknowledge_n,    // Beat acknowledge
    input wire logic read_data_retry_n,         // Retry previous read beat
    input wire logic write_data_release_n,      // Float write data
    input wire logic data_tenure_busy_n_i,      // Busy as seen on the wire
    output logic data_tenure_busy_n_o,          // Busy drive level
    output logic data_tenure_busy_oe,           // Busy drive enable
    input wire logic [31:0] data_high_half_i,   // High half in
    output logic [31:0] data_high_half_o,       // High half out
    output logic data_high_half_oe,             // High half enable
    input wire logic [31:0] data_low_half_i,    // Low half in
    output logic [31:0] data_low_half_o,        // Low half out
    output logic data_low_half_oe,              // Low half enable
    input wire logic [7:0] byte_parity_bits_i,  // Parity in, bit n = lane n
    output logic [7:0] byte_parity_bits_o,      // Parity out
    output logic [7:0] byte_parity_bits_oe,     // Parity enables
    output logic parity_error_flag_n_o,         // Open-drain level, always low
    output logic parity_error_flag_n_oe         // Open-drain enable, high pulls low
);

    generate
        if (BURST_BEATS < 2 || BURST_BEATS > CDBP_BURST_BEATS) begin : g_beats_chk
            $error("cdbp_data_path supports two to four burst beats");
        end
    endgenerate

    cdbp_state_e state_q;
    logic is_write_q, is_dstore_q;
    logic [BW-1:0] beat_q, last_beat_q;
    logic [7:0] lanes_q;
    logic busy_q, drive_q, release_q;
    logic [63:0] dout_q;
    logic rd_ta_q;
    logic [BW-1:0] rd_ta_beat_q;
    logic [7:0] check_mask_q;
    logic perr_s1_q, perr_q;
    logic checkstop_q;

    logic ta, retry, qual_gnt, last_beat, retry_hit;
    logic [63:0] bus_in, wr_masked;
    logic [7:0] gen_par, even_err;
    logic [7:0] sel_lanes;

    // Pin decode
    assign ta = ~transfer_acknowledge_n;
    assign retry = ~read_data_retry_n;
    assign last_beat = (beat_q == last_beat_q);
    assign bus_in = {data_high_half_i, data_low_half_i};
    assign retry_hit = retry && rd_ta_q && !is_write_q;

    // Grant qualifies only when the wire is not busy and no retry is pending
    assign qual_gnt = (state_q == CDBP_WAIT_GNT) && !data_bus_grant_n
                      && data_tenure_busy_n_i && read_data_retry_n;

    // Direct-store is confined to the high half
    assign sel_lanes = req_dstore ? (req_lanes & CDBP_HIGH_LANES) : req_lanes;

    // Zero the unselected lanes so stale core data never leaks onto the bus
    always_comb begin
        for (int n = 0; n < CDBP_LANES; n++) begin
            wr_masked[63 - 8*n -: 8] = lanes_q[n] ? wr_data[63 - 8*n -: 8] : 8'h00;
        end
    end

    // Per-lane parity; parity bit n sits beside lane n
    genvar g;
    generate
        for (g = 0; g < CDBP_LANES; g++) begin : g_lane
            logic [7:0] out_byte, in_byte;
            assign out_byte = dout_q[63 - 8*g -: 8];
            assign in_byte = bus_in[63 - 8*g -: 8];
            cdbp_lane_par u_gen (
                .lane_byte(out_byte),
                .par_in(1'b0),
                .par_gen(gen_par[g]),
                .even_err()
            );
            cdbp_lane_par u_chk (
                .lane_byte(in_byte),
                .par_in(byte_parity_bits_i[g]),
                .par_gen(),
                .even_err(even_err[g])
            );
        end
    endgenerate

    // Core handshakes
    assign req_ready = (state_q == CDBP_IDLE);
    assign wr_pull = is_write_q && ((qual_gnt)
                     || (state_q == CDBP_XFER && ta && !last_beat));

    // Tenure sequencing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CDBP_IDLE;
        end else begin
            case (state_q)
                CDBP_IDLE: begin
                    if (req_valid) begin
                        state_q <= CDBP_WAIT_GNT;
                    end
                end
                CDBP_WAIT_GNT: begin
                    if (qual_gnt) begin
                        state_q <= CDBP_XFER;
                    end
                end
                CDBP_XFER: begin
                    if (retry_hit) begin
                        state_q <= CDBP_XFER;
                    end else if (ta && last_beat) begin
                        state_q <= is_write_q ? CDBP_IDLE : CDBP_RD_TAIL;
                    end
                end
                CDBP_RD_TAIL: begin
                    // Last read beat stays provisional for one retry window
                    state_q <= retry_hit ? CDBP_XFER : CDBP_IDLE;
                end
                default: begin
                    state_q <= CDBP_IDLE;
                end
            endcase
        end
    end

    // Transaction attributes latched at acceptance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            is_write_q <= 1'b0;
            is_dstore_q <= 1'b0;
            lanes_q <= CDBP_LANES_RST;
            last_beat_q <= '0;
            check_mask_q <= CDBP_ALL_LANES;
        end else if (req_ready && req_valid) begin
            is_write_q <= req_write;
            is_dstore_q <= req_dstore;
            lanes_q <= sel_lanes;
            // Direct-store never bursts
            last_beat_q <= (req_burst && !req_dstore) ? BW'(BURST_BEATS - 1)
                                                      : BW'(CDBP_SINGLE_BEATS - 1);
            // Size does not narrow the check; only direct-store does
            check_mask_q <= req_dstore ? CDBP_HIGH_LANES : CDBP_ALL_LANES;
        end
    end

    // Beat counter, rewound when a read beat is retried
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            beat_q <= '0;
        end else if (qual_gnt) begin
            beat_q <= '0;
        end else if (retry_hit) begin
            beat_q <= rd_ta_beat_q;
        end else if (state_q == CDBP_XFER && ta && !last_beat) begin
            beat_q <= beat_q + BW'(1);
        end
    end

    // Memory of the previous read acknowledge for the retry window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ta_q <= 1'b0;
            rd_ta_beat_q <= '0;
        end else begin
            rd_ta_q <= (state_q == CDBP_XFER) && ta && !is_write_q && !retry_hit;
            if (state_q == CDBP_XFER && ta) begin
                rd_ta_beat_q <= beat_q;
            end
        end
    end

    // Busy: on the cycle after grant, off after the final acknowledge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (qual_gnt) begin
            busy_q <= 1'b1;
        end else if (state_q == CDBP_XFER && ta && last_beat && !retry_hit) begin
            busy_q <= 1'b0;
        end
    end

    // Write beat register; loads with the grant and after each acknowledge but the final one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= CDBP_DATA_RST;
        end else if (wr_pull) begin
            dout_q <= wr_masked;
        end
    end

    // Write drive window: grant to final acknowledge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_q <= 1'b0;
        end else if (qual_gnt && is_write_q) begin
            drive_q <= 1'b1;
        end else if (state_q == CDBP_XFER && ta && last_beat) begin
            drive_q <= 1'b0;
        end
    end

    // Release request, sampled only while a write tenure is live
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            release_q <= 1'b0;
        end else begin
            release_q <= !write_data_release_n && is_write_q
                         && (state_q != CDBP_IDLE);
        end
    end

    // Pin drive; release floats data and parity but leaves busy alone
    assign data_high_half_o = dout_q[63:32];
    assign data_low_half_o = dout_q[31:0];
    assign data_high_half_oe = drive_q && !release_q;
    assign data_low_half_oe = drive_q && !release_q;
    // All eight bits carry valid parity even for direct-store writes
    assign byte_parity_bits_o = gen_par;
    assign byte_parity_bits_oe = {CDBP_LANES{data_low_half_oe}};
    assign data_tenure_busy_n_o = 1'b0;
    assign data_tenure_busy_oe = busy_q;

    // Read beats land in the buffer at their acknowledge; retried ones are rewritten
    cdbp_beat_buf #(
        .WIDTH(CDBP_BUS_W),
        .DEPTH(BURST_BEATS),
        .AW(BW)
    ) u_buf (
        .clk(clk),
        .wr_en(state_q == CDBP_XFER && ta && !is_write_q && !retry_hit),
        .wr_addr(beat_q),
        .wr_data(bus_in),
        .rd_addr(rd_idx),
        .rd_data_q(rd_word)
    );

    assign rd_done = (state_q == CDBP_RD_TAIL) && !retry_hit;

    // Parity check at the acknowledge; parity is valid with the data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perr_s1_q <= 1'b0;
            perr_q <= 1'b0;
        end else begin
            perr_s1_q <= parity_check_en && (state_q == CDBP_XFER) && ta && !is_write_q
                         && !retry_hit && |(even_err & check_mask_q);
            perr_q <= perr_s1_q;
        end
    end

    // Open-drain flag pulls low for exactly the one pipeline cycle
    assign parity_error_flag_n_o = 1'b0;
    assign parity_error_flag_n_oe = perr_q;

    // Error routing: machine check if enabled, otherwise stop for good
    assign machine_check_req = perr_q && machine_check_enable;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            checkstop_q <= 1'b0;
        end else if (perr_q && !machine_check_enable) begin
            checkstop_q <= 1'b1;
        end
    end
    assign checkstop = checkstop_q;

    // Checks kept next to the logic they watch
    busy_after_grant_a: assert property (
        @(posedge clk) disable iff (!nrst)
        qual_gnt |=> data_tenure_busy_oe && !data_tenure_busy_n_o)
        else $error("busy did not follow a qualified grant");

    first_beat_with_busy_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (qual_gnt && is_write_q && write_data_release_n)
        |=> data_high_half_oe && data_tenure_busy_oe)
        else $error("first write beat not driven with busy");

    write_float_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_q == CDBP_XFER && is_write_q && ta && last_beat)
        |=> !data_high_half_oe && !data_low_half_oe && !data_tenure_busy_oe)
        else $error("write data still driven after final acknowledge");

    odd_parity_a: assert property (
        @(posedge clk) disable iff (!nrst)
        data_low_half_oe |-> (^{data_high_half_o[31:24], byte_parity_bits_o[0]})
                             && (^{data_low_half_o[7:0], byte_parity_bits_o[7]}))
        else $error("driven parity is not odd");

    parity_tracks_low_a: assert property (
        @(posedge clk) disable iff (!nrst)
        byte_parity_bits_oe == {8{data_low_half_oe}})
        else $error("parity enables differ from low half");

    perr_pulse_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (parity_check_en && state_q == CDBP_XFER && ta && !is_write_q && !retry_hit
         && |(even_err & check_mask_q))
        |-> ##2 parity_error_flag_n_oe)
        else $error("parity error flag timing wrong");

    release_floats_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (!write_data_release_n && is_write_q && state_q == CDBP_XFER && !(ta && last_beat))
        |=> !data_high_half_oe && byte_parity_bits_oe == 8'h00 && data_tenure_busy_oe)
        else $error("release did not float data while keeping busy");

    release_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !is_write_q |-> !data_high_half_oe && !data_low_half_oe)
        else $error("data driven during a read");

    beat_bound_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_q == CDBP_XFER)
        |-> beat_q <= last_beat_q)
        else $error("beat count overran the transaction length");

endmodule

//--- dv/cdbp_sys_model.sv
// Behavioural memory controller: grant, acknowledge, read beats, retry and release.
`timescale 1ns/1ps
module cdbp_sys_model
    import cdbp_pkg::*;
(
    input wire logic clk, // Bus clock
    input wire logic nrst, // Async reset, active low
    input wire logic data_tenure_busy_oe, // Engine owns the data bus
    input wire logic in_read, // Current tenure is a read
    input wire logic [2:0] beats, // Beats to acknowledge
    input wire logic [2:0] retry_at, // Beat to retry once, 7 none
    input wire logic rel_en, // Float request while beat 1 runs
    input wire logic [31:0] rd_base, // Seed of read beat data
    input wire logic [2:0] bad_beat, // Beat given bad parity
    input wire logic [7:0] bad_mask, // Lanes given bad parity
    output logic data_bus_grant_n, // Grant
    output logic transfer_acknowledge_n, // Acknowledge
    output logic read_data_retry_n, // Retry
    output logic write_data_release_n, // Release
    output logic [31:0] m_hi, // High half driven on reads
    output logic [31:0] m_lo, // Low half driven on reads
    output logic [7:0] m_par // Parity driven on reads
);
    int cnt;
    logic rt_done;
    logic bad;
    logic [63:0] d;
    // Pins move 1 ns after the edge; idle data toggles so stale values never match
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {data_bus_grant_n, transfer_acknowledge_n, read_data_retry_n} = 3'h7;
            write_data_release_n = 1'b1;
            {m_hi, m_lo, m_par} = 72'h0;
            cnt = 0;
            rt_done = 1'b0;
        end else begin
            #1;
            read_data_retry_n = 1'b1;
            if (!transfer_acknowledge_n) begin
                if (in_read && cnt == retry_at && !rt_done) begin
                    read_data_retry_n = 1'b0;
                    rt_done = 1'b1;
                end else begin
                    cnt++;
                end
            end
            if (!data_tenure_busy_oe) begin
                cnt = 0;
                rt_done = 1'b0;
            end
            transfer_acknowledge_n = !(data_tenure_busy_oe && read_data_retry_n && cnt < beats
                && $urandom % 2);
            bad = in_read && cnt == retry_at && !rt_done;
            d = {rd_base + 32'(cnt), ~(rd_base + 32'(cnt))};
            // Data and parity only valid in the acknowledge cycle
            if (!transfer_acknowledge_n && in_read) begin
                d = bad ? ~d : d;
                {m_hi, m_lo} = d;
                for (int n = 0; n < 8; n++) begin
                    m_par[n] = ~^d[63-8*n -: 8] ^ (bad_mask[n] && cnt == bad_beat)
                        ^ (bad && n == 0);
                end
            end else begin
                {m_hi, m_lo, m_par} = ~{m_hi, m_lo, m_par};
            end
            data_bus_grant_n = data_tenure_busy_oe | ($urandom % 2);
            write_data_release_n = !(rel_en && data_tenure_busy_oe && cnt == 1);
        end
    end
endmodule

//--- dv/cdbp_data_path_test.sv
// Self-checking bench for the data bus parity path.
`timescale 1ns/1ps
module cdbp_data_path_test;
    import cdbp_pkg::*;
    logic clk = 0, nrst = 0, req_valid = 0, req_write = 0, req_burst = 0, req_dstore = 0;
    logic [7:0] req_lanes = 8'h00, bad_mask = 8'h00;
    logic [63:0] wr_data = 64'h0, e;
    logic [1:0] rd_idx = 2'h0;
    logic parity_check_en = 1, machine_check_enable = 1, in_read = 0, rel_en = 0;
    logic [2:0] beats = 3'h1, retry_at = 3'h7, bad_beat = 3'h7;
    logic [31:0] rd_base = 32'h0, m_hi, m_lo, data_high_half_i, data_low_half_i;
    logic [31:0] data_high_half_o, data_low_half_o;
    logic [7:0] m_par, byte_parity_bits_i, byte_parity_bits_o, byte_parity_bits_oe;
    logic req_ready, wr_pull, rd_done, machine_check_req, checkstop, data_bus_grant_n;
    logic transfer_acknowledge_n, read_data_retry_n, write_data_release_n, data_tenure_busy_n_i;
    logic data_tenure_busy_n_o, data_tenure_busy_oe, data_high_half_oe, data_low_half_oe;
    logic parity_error_flag_n_oe, dstore_q = 0, rd_chk = 0, last = 0, p1 = 0, p2 = 0;
    logic busy_prev = 0, rel_prev = 1;
    logic [63:0] rd_word, wbeat [4];
    logic [63:0] exp_q [$];
    int mismatches = 0, tests_run = 0, widx = 0, cyc = 0;
    cdbp_data_path dut (.clk, .nrst, .req_valid, .req_ready, .req_write, .req_burst,
        .req_dstore, .req_lanes, .wr_pull, .wr_data, .rd_done, .rd_idx, .rd_word,
        .parity_check_en, .machine_check_enable, .machine_check_req, .checkstop,
        .data_bus_grant_n, .transfer_acknowledge_n, .read_data_retry_n, .write_data_release_n,
        .data_tenure_busy_n_i, .data_tenure_busy_n_o, .data_tenure_busy_oe, .data_high_half_i,
        .data_high_half_o, .data_high_half_oe, .data_low_half_i, .data_low_half_o,
        .data_low_half_oe, .byte_parity_bits_i, .byte_parity_bits_o, .byte_parity_bits_oe,
        .parity_error_flag_n_o(), .parity_error_flag_n_oe);
    cdbp_sys_model sys (.clk, .nrst, .data_tenure_busy_oe, .in_read, .beats, .retry_at,
        .rel_en, .rd_base, .bad_beat, .bad_mask, .data_bus_grant_n, .transfer_acknowledge_n,
        .read_data_retry_n, .write_data_release_n, .m_hi, .m_lo, .m_par);
    // Wire levels: whoever enables drives; busy has a pull-up
    assign data_tenure_busy_n_i = data_tenure_busy_oe ? data_tenure_busy_n_o : 1'b1;
    assign data_high_half_i = data_high_half_oe ? data_high_half_o : m_hi;
    assign data_low_half_i = data_low_half_oe ? data_low_half_o : m_lo;
    assign byte_parity_bits_i = (byte_parity_bits_oe & byte_parity_bits_o)
        | (~byte_parity_bits_oe & m_par);
    always #4 clk = ~clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] odd(input logic [63:0] d);
        logic [7:0] r;
        for (int n = 0; n < 8; n++) r[n] = ~^d[63-8*n -: 8];
        return r;
    endfunction
    function automatic logic [63:0] lmask(input logic [7:0] l);
        logic [63:0] r;
        for (int n = 0; n < 8; n++) r[63-8*n -: 8] = {8{l[n]}};
        return r;
    endfunction
    task automatic close_out;
        if (mismatches == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Next write beat is presented once the engine has pulled the current one
    always @(posedge clk) begin
        if (req_valid && req_ready === 1'b1) widx = 0;
        else if (wr_pull === 1'b1) widx = widx + 1;
        #1 wr_data = wbeat[widx % 4];
    end
    // One transaction: note expectations, offer it, wait for the end, fetch reads
    task automatic op(input logic w, b, ds, input logic [7:0] ln, input logic rl,
        input logic [2:0] rt, bb, input logic [7:0] bm);
        int n, t;
        n = (b && !ds) ? CDBP_BURST_BEATS : CDBP_SINGLE_BEATS;
        t = 0;
        rd_base = $urandom;
        for (int k = 0; k < 4; k++) begin
            wbeat[k] = {$urandom, $urandom};
            if (w && k < n) exp_q.push_back(wbeat[k] & lmask(ds ? ln & CDBP_HIGH_LANES : ln));
        end
        {in_read, rel_en, retry_at, bad_beat, bad_mask, dstore_q} = {!w, rl, rt, bb, bm, ds};
        beats = 3'(n);
        {req_write, req_burst, req_dstore, req_lanes, req_valid} = {w, b, ds, ln, 1'b1};
        @(posedge clk);
        #1 req_valid = 0;
        while (req_ready !== 1'b1 && t < 200) begin
            @(posedge clk);
            #1 t++;
        end
        check(t < 200, 1);
        for (int k = 0; k < n && !w; k++) begin
            rd_idx = 2'(k);
            rd_chk = 0;
            @(posedge clk);
            #1 exp_q.push_back({rd_base + 32'(k), ~(rd_base + 32'(k))});
            rd_chk = 1;
            @(posedge clk);
            #1 rd_chk = 0;
        end
        repeat (3) @(posedge clk);
        #1 check(exp_q.size(), 0);
    endtask
    // Observer at mid-cycle, where every output has settled
    always @(negedge clk) begin
        if (nrst) begin
            if (!in_read && !transfer_acknowledge_n && data_tenure_busy_oe) begin
                e = exp_q.pop_front();
                if (data_high_half_oe) check({data_high_half_o, data_low_half_o}, e);
                if (data_low_half_oe) check(byte_parity_bits_o, odd(e));
                last = exp_q.size() == 0;
            end else if (last) begin
                check({data_high_half_oe, data_low_half_oe, |byte_parity_bits_oe}, 0);
                last = 0;
            end
            if (!in_read && data_tenure_busy_oe && !busy_prev) check(data_high_half_oe, rel_prev);
            if (!in_read && !rel_prev) check({data_high_half_oe, data_low_half_oe}, 0);
            if (in_read) check({data_high_half_oe, data_low_half_oe}, 0);
            check(byte_parity_bits_oe, {8{data_low_half_oe}});
            check(parity_error_flag_n_oe, p2);
            check(machine_check_req, parity_error_flag_n_oe & machine_check_enable);
            if (rd_chk) check(rd_word, exp_q.pop_front());
            // A retried beat still flags: the check runs at its acknowledge
            p2 = p1;
            p1 = in_read && !transfer_acknowledge_n && parity_check_en
                && |((odd({data_high_half_i, data_low_half_i}) ^ byte_parity_bits_i)
                & (dstore_q ? CDBP_HIGH_LANES : CDBP_ALL_LANES));
            busy_prev = data_tenure_busy_oe;
            rel_prev = write_data_release_n;
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        void'($urandom(78));
        repeat (4) @(posedge clk);
        #1 nrst = 1;
        op(1, 0, 0, $urandom, 0, 7, 7, 0);
        op(1, 1, 0, 8'hFF, 1, 7, 7, 0);
        op(1, 1, 1, 8'hFF, 0, 7, 7, 0);
        op(0, 0, 0, 8'hFF, 0, 7, 0, 8'h20);
        op(0, 1, 0, 8'hFF, 1, 1, 2, 8'h08);
        op(0, 0, 1, 8'hFF, 0, 7, 0, 8'hF0);
        op(0, 0, 1, 8'hFF, 0, 7, 0, 8'h01);
        for (int i = 0; i < 6; i++) op($urandom % 2, 1, 0, $urandom, 0, 7, 3, $urandom);
        parity_check_en = 0;
        op(0, 0, 0, 8'hFF, 0, 7, 0, 8'hFF);
        parity_check_en = 1;
        check(checkstop, 0);
        machine_check_enable = 0;
        op(0, 0, 0, 8'hFF, 0, 7, 0, 8'h80);
        check(checkstop, 1);
        close_out;
    end
endmodule
